/* File: sofb_pkg.sv */
/*
  Package for the serial output frame builder: register map, field
  positions, reset values, pattern codes and the packed carriers.
  Assumes a 32-bit register port with byte addresses on word bounds.
*/
`default_nettype none

package sofb_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] SOFB_CTL_OFS = 8'h10;
  localparam logic [7:0] SOFB_RNG_OFS = 8'h14;

  // Frame content control field positions
  localparam int SOFB_ADDR_EN_POS = 14;
  localparam int SOFB_SUP_SEL_POS = 12;
  localparam int SOFB_IN_SEL_POS = 10;
  localparam int SOFB_RNG_EN_POS = 8;
  localparam int SOFB_PARITY_APPEND_ENABLE_POS = 3;
  localparam int SOFB_PAT_POS = 0;

  // Range and reference control field positions
  localparam int SOFB_REF_OFF_POS = 6;
  localparam int SOFB_RNG_CODE_POS = 0;

  // Writable bits of each register, all others read zero
  localparam logic [31:0] SOFB_CTL_RW_MASK = 32'h0000_7d0f;
  localparam logic [31:0] SOFB_RNG_RW_MASK = 32'h0000_004f;

  // ------------------------------------------------------------
  // Field widths and reset values
  // ------------------------------------------------------------
  localparam int SOFB_DATA_W = 16;
  localparam int SOFB_FRAME_W = 32;
  localparam logic [5:0] SOFB_DATA_LEN = 6'h10;
  localparam logic [3:0] SOFB_RNG_CODE_RST = 4'h0;
  localparam logic SOFB_REF_OFF_RST = 1'b0;
  localparam logic [15:0] SOFB_DATA_RST = 16'h0000;

  // ------------------------------------------------------------
  // Output pattern codes and words
  // ------------------------------------------------------------
  localparam logic [2:0] SOFB_PAT_ZERO = 3'h4;
  localparam logic [2:0] SOFB_PAT_ONES = 3'h5;
  localparam logic [2:0] SOFB_PAT_ALT1 = 3'h6;
  localparam logic [2:0] SOFB_PAT_ALT2 = 3'h7;
  localparam logic [15:0] SOFB_ALT1_WORD = 16'h5555;
  localparam logic [15:0] SOFB_ALT2_WORD = 16'h3333;

  // Range codes: bipolar up to 4, unipolar 8 to 11
  localparam logic [3:0] SOFB_RNG_BI_MAX = 4'h4;
  localparam logic [3:0] SOFB_RNG_UNI_MIN = 4'h8;
  localparam logic [3:0] SOFB_RNG_UNI_MAX = 4'hb;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic addr_en;
    logic [1:0] sup_sel;
    logic [1:0] in_sel;
    logic rng_en;
    logic parity_append_enable;
    logic [2:0] pattern;
  } sofb_ctl_t;

  typedef struct packed {
    logic vdd_h;
    logic vdd_l;
    logic in_h;
    logic in_l;
  } sofb_alarm_t;

  typedef struct packed {
    logic [31:0] bits;
    logic [5:0] len;
  } sofb_frame_t;

  localparam sofb_ctl_t SOFB_CTL_RST = '0;

endpackage : sofb_pkg

`default_nettype wire

/* File: sofb_sync3.sv */
/*
  Three-stage synchroniser with agreement filter for pin inputs.
  Assumes inputs are asynchronous to the clock.
*/
`default_nettype none

module sofb_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Stages; a change counts once stage two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_out <= (s2_q & s3_q) | (q_out & (s2_q ^ s3_q));
    end
  end

endmodule : sofb_sync3

`default_nettype wire

/* File: sofb_buf2.sv */
/*
  Small valid/ready buffer, two entries by default.
  Assumes both sides on the same clock; ready is registered.
*/
`default_nettype none

module sofb_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  wire push_w = in_valid_in && in_ready_out;
  wire pop_w = out_valid_out && out_ready_in;

  // Occupancy after this cycle
  assign cnt_d = cnt_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];

  // Storage and pointers
  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_out <= 1'b1;
    end else begin
      if (push_w) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      if (pop_w) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      end
      cnt_q <= cnt_d;
      in_ready_out <= (cnt_d != (PW+1)'(DEPTH));
    end
  end

endmodule : sofb_buf2

`default_nettype wire

/* File: sofb_frame_builder.sv */
/*
  Serial output frame builder: holds the frame content control and
  range/reference control registers, composes each output frame and
  shifts it out on one serial output line.
  Assumes conversion words and alarm flags come from logic on SYS_CLK_IN;
  link clock and frame select come from the host and are asynchronous.
*/
// The address-and-strobe port is this design's own decision.
`default_nettype none

module sofb_frame_builder
  import sofb_pkg::*;
#(
  parameter int DATA_W = SOFB_DATA_W,
  parameter int BUF_DEPTH = 2
) (
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic APP_RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input wire logic [DATA_W-1:0] CONV_DATA_IN,
  input wire logic CONV_VALID_IN,
  output logic CONV_READY_OUT,
  input wire sofb_alarm_t ALARM_FLAGS_IN,
  input wire logic [3:0] DEV_ADDR_IN,
  input wire logic LINK_CLK_IN,
  input wire logic LINK_SEL_N_IN,
  output logic SER_OUT_LINE_OUT,
  output logic SER_OUT_OE_N_OUT,
  output logic REF_OFF_OUT,
  output logic [3:0] RANGE_CODE_OUT,
  output logic RANGE_UNIPOLAR_OUT,
  output logic RANGE_LEGAL_OUT
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} sofb_state_t;
  sofb_state_t state_q;
  sofb_ctl_t ctl_q;
  logic ref_off_q;
  logic [3:0] range_code_q;
  logic [15:0] last_q;
  logic [31:0] shift_q;
  logic [5:0] left_q;
  logic link_clk_prev_q, link_sel_prev_q;
  logic [1:0] link_sync_w;
  logic [31:0] ctl_word_w, rng_word_w;
  logic [31:0] acc;
  logic [5:0] n, len_pre_w;
  sofb_frame_t frame_w;
  logic buf_valid_w, load_w;
  logic [DATA_W-1:0] buf_data_w;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire ctl_hit_w = (REG_ADDR_IN == SOFB_CTL_OFS);
  wire rng_hit_w = (REG_ADDR_IN == SOFB_RNG_OFS);
  wire ctl_wr_w = REG_WR_IN && ctl_hit_w;
  wire rng_wr_w = REG_WR_IN && rng_hit_w;

  // Read views of the two registers
  always_comb begin
    ctl_word_w = '0;
    ctl_word_w[SOFB_ADDR_EN_POS] = ctl_q.addr_en;
    ctl_word_w[SOFB_SUP_SEL_POS +: 2] = ctl_q.sup_sel;
    ctl_word_w[SOFB_IN_SEL_POS +: 2] = ctl_q.in_sel;
    ctl_word_w[SOFB_RNG_EN_POS] = ctl_q.rng_en;
    ctl_word_w[SOFB_PARITY_APPEND_ENABLE_POS] = ctl_q.parity_append_enable;
    ctl_word_w[SOFB_PAT_POS +: 3] = ctl_q.pattern;
    rng_word_w = '0;
    rng_word_w[SOFB_REF_OFF_POS] = ref_off_q;
    rng_word_w[SOFB_RNG_CODE_POS +: 4] = range_code_q;
  end

  // reserved read zero, unmapped read zero
  wire [31:0] rdata_w = ctl_hit_w ? (ctl_word_w & SOFB_CTL_RW_MASK) :
                        rng_hit_w ? (rng_word_w & SOFB_RNG_RW_MASK) : '0;

  // Read data stands for one cycle only
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REG_RDATA_OUT <= '0;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? rdata_w : '0;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Frame content control; parity enable survives app reset
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctl_q <= SOFB_CTL_RST;
    end else if (APP_RST_IN) begin
      ctl_q <= '{default: '0, parity_append_enable: ctl_q.parity_append_enable};
    end else if (ctl_wr_w) begin
      ctl_q.addr_en <= REG_WDATA_IN[SOFB_ADDR_EN_POS];
      ctl_q.sup_sel <= REG_WDATA_IN[SOFB_SUP_SEL_POS +: 2];
      ctl_q.in_sel <= REG_WDATA_IN[SOFB_IN_SEL_POS +: 2];
      ctl_q.rng_en <= REG_WDATA_IN[SOFB_RNG_EN_POS];
      ctl_q.parity_append_enable <= REG_WDATA_IN[SOFB_PARITY_APPEND_ENABLE_POS];
      ctl_q.pattern <= REG_WDATA_IN[SOFB_PAT_POS +: 3];
    end
  end

  // app reset clears only reference off
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ref_off_q <= SOFB_REF_OFF_RST;
      range_code_q <= SOFB_RNG_CODE_RST;
    end else if (APP_RST_IN) begin
      ref_off_q <= SOFB_REF_OFF_RST;
    end else if (rng_wr_w) begin
      ref_off_q <= REG_WDATA_IN[SOFB_REF_OFF_POS];
      range_code_q <= REG_WDATA_IN[SOFB_RNG_CODE_POS +: 4];
    end
  end

  wire rng_bi_w = (range_code_q <= SOFB_RNG_BI_MAX);
  wire rng_uni_w = (range_code_q >= SOFB_RNG_UNI_MIN) && (range_code_q <= SOFB_RNG_UNI_MAX);

  // Analog-facing status outputs
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REF_OFF_OUT <= SOFB_REF_OFF_RST;
      RANGE_CODE_OUT <= SOFB_RNG_CODE_RST;
      RANGE_UNIPOLAR_OUT <= 1'b0;
      RANGE_LEGAL_OUT <= 1'b1;
    end else begin
      REF_OFF_OUT <= ref_off_q;
      RANGE_CODE_OUT <= range_code_q;
      RANGE_UNIPOLAR_OUT <= rng_uni_w;
      RANGE_LEGAL_OUT <= rng_bi_w || rng_uni_w;
    end
  end

  // ------------------------------------------------------------
  // Conversion word buffer
  // ------------------------------------------------------------
  sofb_buf2 #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(ARST_N_IN),
    .in_valid_in(CONV_VALID_IN),
    .in_ready_out(CONV_READY_OUT),
    .in_data_in(CONV_DATA_IN),
    .out_valid_out(buf_valid_w),
    .out_ready_in(load_w),
    .out_data_out(buf_data_w)
  );

  // Fresh word if one waits, else the last word again
  wire [15:0] cur_data_w = buf_valid_w ? 16'(buf_data_w) : last_q;

  wire [15:0] pat_word_w = !ctl_q.pattern[2] ? cur_data_w :
                           (ctl_q.pattern == SOFB_PAT_ZERO) ? 16'h0000 :
                           (ctl_q.pattern == SOFB_PAT_ONES) ? 16'hffff :
                           (ctl_q.pattern == SOFB_PAT_ALT1) ? SOFB_ALT1_WORD : SOFB_ALT2_WORD;

  // ------------------------------------------------------------
  // Frame composition, MSB first, left-justified
  // ------------------------------------------------------------
  always_comb begin
    acc = '0;
    acc[31 -: 16] = pat_word_w;
    n = SOFB_DATA_LEN;
    if (ctl_q.addr_en) begin
      acc[31 - n -: 4] = DEV_ADDR_IN;
      n = n + 6'h4;
    end
    if (ctl_q.sup_sel[0]) begin
      acc[31 - n] = ALARM_FLAGS_IN.vdd_h;
      n = n + 6'h1;
    end
    if (ctl_q.sup_sel[1]) begin
      acc[31 - n] = ALARM_FLAGS_IN.vdd_l;
      n = n + 6'h1;
    end
    if (ctl_q.in_sel[0]) begin
      acc[31 - n] = ALARM_FLAGS_IN.in_h;
      n = n + 6'h1;
    end
    if (ctl_q.in_sel[1]) begin
      acc[31 - n] = ALARM_FLAGS_IN.in_l;
      n = n + 6'h1;
    end
    if (ctl_q.rng_en) begin
      acc[31 - n -: 4] = range_code_q;
      n = n + 6'h4;
    end
    len_pre_w = n;
    if (ctl_q.parity_append_enable) begin
      acc[31 - n] = ^pat_word_w;
      n = n + 6'h1;
      acc[31 - n] = ^acc;
      n = n + 6'h1;
    end
    frame_w.bits = acc;
    frame_w.len = n;
  end

  // ------------------------------------------------------------
  // Link side: synchronised host clock and frame select
  // ------------------------------------------------------------
  sofb_sync3 #(
    .W(2),
    .RST_VAL(2'h1)
  ) u_sync (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(ARST_N_IN),
    .d_in({LINK_CLK_IN, LINK_SEL_N_IN}),
    .q_out(link_sync_w)
  );

  wire link_clk_w = link_sync_w[1];
  wire link_sel_n_w = link_sync_w[0];
  wire clk_rise_w = link_clk_w && !link_clk_prev_q;
  wire sel_fall_w = !link_sel_n_w && link_sel_prev_q;
  wire sel_rise_w = link_sel_n_w && !link_sel_prev_q;
  assign load_w = (state_q == ST_IDLE) && sel_fall_w;

  // Edge history
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      link_clk_prev_q <= 1'b0;
      link_sel_prev_q <= 1'b1;
    end else begin
      link_clk_prev_q <= link_clk_w;
      link_sel_prev_q <= link_sel_n_w;
    end
  end

  // Last word sent, repeated while no new word waits
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      last_q <= SOFB_DATA_RST;
    end else if (load_w) begin
      last_q <= cur_data_w;
    end
  end

  // Shifter: first bit on select fall, next bit per link clock rise
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      left_q <= '0;
      SER_OUT_LINE_OUT <= 1'b0;
      SER_OUT_OE_N_OUT <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sel_fall_w) begin
            state_q <= ST_SHIFT;
            shift_q <= {frame_w.bits[30:0], 1'b0};
            left_q <= frame_w.len - 6'h1;
            SER_OUT_LINE_OUT <= frame_w.bits[31];
            SER_OUT_OE_N_OUT <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (sel_rise_w) begin
            state_q <= ST_IDLE;
            SER_OUT_LINE_OUT <= 1'b0;
            SER_OUT_OE_N_OUT <= 1'b1;
          end else if (clk_rise_w) begin
            SER_OUT_LINE_OUT <= (left_q != '0) && shift_q[31];
            shift_q <= {shift_q[30:0], 1'b0};
            left_q <= (left_q != '0) ? left_q - 6'h1 : '0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  wire no_app_w = !ctl_q.addr_en && (ctl_q.sup_sel == 2'h0) && (ctl_q.in_sel == 2'h0);
  sequence s_ctl_read;
    REG_RD_IN && ctl_hit_w;
  endsequence
  sequence s_rng_read;
    REG_RD_IN && rng_hit_w;
  endsequence
  sequence s_load;
    (state_q == ST_IDLE) && sel_fall_w;
  endsequence
  AST_ADDR_FIELD: assert property (ctl_q.addr_en |-> frame_w.bits[15:12] == DEV_ADDR_IN)
    else $error("device address missing from frame");
  AST_SUPPLY_HIGH: assert property (!ctl_q.addr_en && ctl_q.sup_sel == 2'h1 |->
    frame_w.bits[15] == ALARM_FLAGS_IN.vdd_h)
    else $error("supply high flag misplaced");
  AST_INPUT_BOTH: assert property (!ctl_q.addr_en && ctl_q.sup_sel == 2'h0 && ctl_q.in_sel == 2'h3 |->
    frame_w.bits[15:14] == {ALARM_FLAGS_IN.in_h, ALARM_FLAGS_IN.in_l})
    else $error("input flags misplaced");
  AST_RANGE_FIELD: assert property (no_app_w && ctl_q.rng_en |-> frame_w.bits[15:12] == range_code_q)
    else $error("range code misplaced");
  AST_FIELD_ORDER: assert property (ctl_q.addr_en && ctl_q.sup_sel == 2'h0 && ctl_q.in_sel == 2'h0 &&
    ctl_q.rng_en |-> frame_w.bits[11:8] == range_code_q)
    else $error("range code not after address");
  AST_PAR_TAIL: assert property (ctl_q.parity_append_enable |-> frame_w.bits[33 - frame_w.len] == ^pat_word_w)
    else $error("data parity not second to last");
  AST_PAR_DATA: assert property (ctl_q.parity_append_enable && no_app_w && !ctl_q.rng_en |->
    frame_w.bits[15] == ^frame_w.bits[31:16])
    else $error("data parity wrong");
  AST_PAR_FRAME: assert property (ctl_q.parity_append_enable |-> ^frame_w.bits == 1'b0)
    else $error("frame parity not even");
  AST_PAR_LEN: assert property (frame_w.len - len_pre_w == {4'h0, ctl_q.parity_append_enable, 1'b0})
    else $error("parity length wrong");
  AST_LOAD_COUNT: assert property (s_load |=> left_q == $past(frame_w.len) - 6'h1 && !SER_OUT_OE_N_OUT)
    else $error("frame length not loaded");
  AST_PAT_CONV: assert property (!ctl_q.pattern[2] |-> frame_w.bits[31:16] == cur_data_w)
    else $error("conversion data not sent");
  AST_PAT_FIXED: assert property (ctl_q.pattern == SOFB_PAT_ONES |-> frame_w.bits[31:16] == 16'hffff)
    else $error("all ones pattern wrong");
  AST_PAT_ALT: assert property (ctl_q.pattern == SOFB_PAT_ALT2 |-> frame_w.bits[31:16] == SOFB_ALT2_WORD)
    else $error("pair pattern wrong");
  AST_CTL_RESV: assert property (s_ctl_read |=> (REG_RDATA_OUT & ~SOFB_CTL_RW_MASK) == '0)
    else $error("reserved control bits not zero");
  AST_RNG_READ: assert property (s_rng_read |=> (REG_RDATA_OUT & ~SOFB_RNG_RW_MASK) == '0 &&
    REG_RDATA_OUT[3:0] == $past(range_code_q))
    else $error("range register read wrong");
  AST_APP_RST: assert property (APP_RST_IN |=> !ref_off_q && range_code_q == $past(range_code_q))
    else $error("app reset effect wrong");
endmodule : sofb_frame_builder

`default_nettype wire

/* File: sofb_host_model.sv */
/*
  Host model that reads one serial output frame per start pulse.
  Assumes the device changes its bit after each link clock rise.
*/
`default_nettype none
module sofb_host_model (
  input wire logic start_in,
  input wire logic [5:0] len_in,
  input wire logic line_in,
  input wire logic oe_n_in,
  output logic link_clk_out,
  output logic sel_n_out,
  output logic busy_out,
  output logic [31:0] frame_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  // Idle: clock still, select high
  initial begin
    link_clk_out = 1'b0;
    sel_n_out = 1'b1;
    busy_out = 1'b0;
    frame_out = '0;
  end
  always @(posedge start_in) begin
    busy_out = 1'b1;
    #7;
    frame_out = '0;
    sel_n_out = 1'b0;
    #320;
    for (int k = 0; k < int'(len_in); k++) begin
      last = oe_n_in ? ~last : line_in; // Released line shows no old bit
      frame_out[31-k] = last;
      if (k < int'(len_in) - 1) begin
        link_clk_out = 1'b1;
        #160;
        link_clk_out = 1'b0;
        #160;
      end
    end
    sel_n_out = 1'b1;
    #400;
    busy_out = 1'b0;
  end
endmodule : sofb_host_model
`default_nettype wire

/* File: testbench.sv */
/*
  Self-checking bench: registers, range decode, buffer, frames.
  Assumes the host model and the frame builder sources.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sofb_pkg::*;
  logic clk, arst_n, app_rst, wr, rd, cv, start, ready, line, oe_n, lclk, sel_n, busy, ref_off, unip, legal;
  logic rd_q = 1'b0;
  logic [7:0] addr;
  logic [31:0] wd, rdata, seed, r, frame;
  logic [15:0] cd, ctl;
  logic [3:0] dev, rng, rcode;
  logic [5:0] len;
  logic [37:0] e;
  logic [79:0] dl = 80'h0c00_4100_0108_000d_1107;
  sofb_alarm_t fl;
  int fails, cmp_count, cyc;
  logic [31:0] rq[$], fq[$];
  sofb_frame_builder dut (
    .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .APP_RST_IN(app_rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .CONV_DATA_IN(cd), .CONV_VALID_IN(cv), .CONV_READY_OUT(ready), .ALARM_FLAGS_IN(fl),
    .DEV_ADDR_IN(dev), .LINK_CLK_IN(lclk), .LINK_SEL_N_IN(sel_n), .SER_OUT_LINE_OUT(line),
    .SER_OUT_OE_N_OUT(oe_n), .REF_OFF_OUT(ref_off), .RANGE_CODE_OUT(rcode),
    .RANGE_UNIPOLAR_OUT(unip), .RANGE_LEGAL_OUT(legal));
  sofb_host_model host (.start_in(start), .len_in(len), .line_in(line), .oe_n_in(oe_n),
    .link_clk_out(lclk), .sel_n_out(sel_n), .busy_out(busy), .frame_out(frame));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Expected frame, left aligned, with its length
  function automatic logic [37:0] exp_frame(logic [15:0] c, logic [15:0] w, sofb_alarm_t f, logic [3:0] dv,
                                            logic [3:0] rg);
    logic [31:0] v;
    logic [5:0] n;
    logic dp;
    case (c[2:0])
      3'h4: v = 32'h0;
      3'h5: v = 32'hffff;
      3'h6: v = 32'h5555;
      3'h7: v = 32'h3333;
      default: v = {16'h0, w};
    endcase
    dp = ^v;
    n = 6'h10;
    if (c[14]) begin
      v = {v[27:0], dv};
      n = n + 6'h4;
    end
    if (c[12]) begin
      v = {v[30:0], f.vdd_h};
      n = n + 6'h1;
    end
    if (c[13]) begin
      v = {v[30:0], f.vdd_l};
      n = n + 6'h1;
    end
    if (c[10]) begin
      v = {v[30:0], f.in_h};
      n = n + 6'h1;
    end
    if (c[11]) begin
      v = {v[30:0], f.in_l};
      n = n + 6'h1;
    end
    if (c[8]) begin
      v = {v[27:0], rg};
      n = n + 6'h4;
    end
    if (c[3]) begin
      v = {v[29:0], dp, ^v ^ dp};
      n = n + 6'h2;
    end
    return {v << (32 - int'(n)), n};
  endfunction : exp_frame
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  task automatic send(input logic [15:0] d);
    logic ok;
    ok = 1'b0;
    cd <= d;
    cv <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(negedge clk);
      ok = (ready === 1'b1);
      @(posedge clk);
    end
    cv <= 1'b0;
    if (!ok) fails++;
    @(posedge clk);
  endtask : send
  task automatic frame_rd(input logic [15:0] w);
    int n;
    n = 0;
    e = exp_frame(ctl, w, fl, dev, rng);
    fq.push_back(e[37:6]);
    len <= e[5:0];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    if (n >= 2000) fails++;
    @(posedge clk);
  endtask : frame_rd
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // Clock, watchers and timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk("rdata", rdata, rq.pop_front());
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  always @(negedge busy) begin
    if (fq.size() > 0) chk("frame", frame, fq.pop_front());
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h5ebd;
    {arst_n, app_rst, wr, rd, cv, start, addr, wd, cd, dev, fl, ctl, rng} = '0;
    len = 6'h10;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_reg(SOFB_CTL_OFS, 32'h0);
    rd_reg(SOFB_RNG_OFS, 32'h0);
    wr_reg(SOFB_CTL_OFS, 32'hffff_ffff);
    rd_reg(SOFB_CTL_OFS, 32'h0000_7d0f);
    wr_reg(SOFB_RNG_OFS, 32'hffff_ffff);
    rd_reg(SOFB_RNG_OFS, 32'h0000_004f);
    chk("ref_off", {31'h0, ref_off}, 32'h1);
    rd_reg(8'h18, 32'h0);
    app_rst <= 1'b1;
    @(posedge clk);
    app_rst <= 1'b0;
    @(posedge clk);
    rd_reg(SOFB_CTL_OFS, 32'h0000_0008);
    rd_reg(SOFB_RNG_OFS, 32'h0000_000f);
    chk("ref_off", {31'h0, ref_off}, 32'h0);
    for (int c = 0; c < 16; c++) begin
      rng = c[3:0];
      wr_reg(SOFB_RNG_OFS, {28'h0, rng});
      @(negedge clk);
      chk("range", {28'h0, rcode}, {28'h0, rng});
      chk("unipolar", {31'h0, unip}, {31'h0, c >= 8 && c <= 11});
      chk("legal", {31'h0, legal}, {31'h0, c <= 4 || (c >= 8 && c <= 11)});
      @(posedge clk);
    end
    wr_reg(SOFB_CTL_OFS, 32'h0);
    send(16'h1234);
    send(16'hbeef);
    @(negedge clk);
    chk("ready", {31'h0, ready}, 32'h0);
    @(posedge clk);
    frame_rd(16'h1234);
    frame_rd(16'hbeef);
    for (int i = 0; i < 32; i++) begin
      r = xs();
      ctl = {1'b0, r[0], i[4:3], r[2:1], 1'b0, r[3], 4'h0, r[4], i[2:0]};
      rng = r[8:5];
      dev <= r[12:9];
      fl <= sofb_alarm_t'(r[16:13]);
      wr_reg(SOFB_CTL_OFS, {16'h0, ctl});
      wr_reg(SOFB_RNG_OFS, {28'h0, rng});
      r = xs();
      send(r[15:0]);
      frame_rd(r[15:0]);
    end
    // Directed field mixes; no new word waits, so the last one is resent
    for (int j = 0; j < 5; j++) begin
      ctl = dl[79 - 16 * j -: 16];
      wr_reg(SOFB_CTL_OFS, {16'h0, ctl});
      frame_rd(r[15:0]);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
